/* File: key_switch_model.sv */
`timescale 1ns/1ps

// A pressed key shows its active level; a released key floats to the
// enabled resistor, or without one to its deasserted level
module key_switch_model (
    input  wire logic [7:0] press,
    input  wire logic [7:0] act,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] pulldown_en,
    output logic      [7:0] key_pin
);
    assign key_pin = (press & act) | (~press & (pullup_en | (~pulldown_en & ~act)));
endmodule

/* File: key_wake_irq_assertions.sv */
`timescale 1ns/1ps

module key_wake_irq_assertions #(
    parameter int PINS = 8
) (
    input wire logic            core_clk,
    input wire logic            sys_rst,
    input wire logic            hsel,
    input wire logic [31:0]     haddr,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic [2:0]      hsize,
    input wire logic            hready,
    input wire logic [31:0]     hwdata,
    input wire logic [31:0]     hrdata,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic [PINS-1:0] key_pin,
    input wire logic [PINS-1:0] pullup_en,
    input wire logic [PINS-1:0] pulldown_en,
    input wire logic            key_irq
);
    // ------------------------------------------------------------------
    // Ages of the last bus write and the last pin change
    // ------------------------------------------------------------------
    logic [3:0] wr_age_ff;
    logic [3:0] pin_age_ff;
    logic       taken;
    assign taken = hsel && hready && htrans[1];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_age_ff <= 4'hf;
        end else if (taken && hwrite) begin
            wr_age_ff <= 4'h0;
        end else if (wr_age_ff != 4'hf) begin
            wr_age_ff <= wr_age_ff + 4'h1;
        end
    end

    // Saturates so a long quiet spell never wraps into a false young age
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_age_ff <= 4'hf;
        end else if (key_pin != $past(key_pin)) begin
            pin_age_ff <= 4'h0;
        end else if (pin_age_ff != 4'hf) begin
            pin_age_ff <= pin_age_ff + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence rd_ctrl;
        taken && !hwrite && haddr[7:0] == key_wake_irq_pkg::key_ctrl_status_off;
    endsequence
    sequence rd_unmapped;
        taken && !hwrite && haddr[7:0] > key_wake_irq_pkg::event_mask_off;
    endsequence

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    chk_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout dropped");
    chk_pull_excl: assert property ((pullup_en & pulldown_en) == '0)
        else $error("pullup and pulldown both on");
    chk_pull_by_write: assert property (!$stable(pullup_en) || !$stable(pulldown_en)
        |-> wr_age_ff <= 4'h3)
        else $error("pull changed without a write");
    chk_ack_reads_zero: assert property (rd_ctrl |=> hrdata[31:4] == '0 && !hrdata[2])
        else $error("ack or unused bits read nonzero");
    chk_unmapped_zero: assert property (rd_unmapped |=> hrdata == 32'h0)
        else $error("unmapped read nonzero");
    chk_irq_held: assert property ($fell(key_irq) |-> wr_age_ff <= 4'h4)
        else $error("irq dropped without a write");
    chk_irq_cause: assert property ($rose(key_irq)
        |-> wr_age_ff <= 4'h6 || pin_age_ff <= 4'h6)
        else $error("irq rose without a cause");
    cov_irq: cover property ($rose(key_irq));
endmodule

bind key_wake_irq_unit key_wake_irq_assertions #(.PINS(PINS)) key_wake_irq_assertions_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .key_pin(key_pin), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .key_irq(key_irq));

/* File: key_wake_irq_pkg.sv */
package key_wake_irq_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] key_ctrl_status_off = 8'h00;
    localparam logic [7:0] pin_enable_off      = 8'h04;
    localparam logic [7:0] polarity_select_off = 8'h08;
    localparam logic [7:0] port_pull_off       = 8'h0c;
    localparam logic [7:0] event_status_off    = 8'h10;
    localparam logic [7:0] event_mask_off      = 8'h14;

    // ------------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------------
    localparam int mode_bit   = 0;
    localparam int irq_en_bit = 1;
    localparam int ack_bit    = 2;
    localparam int flag_bit   = 3;

    // ------------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------------
    localparam int evt_edge_bit  = 0;
    localparam int evt_level_bit = 1;
    localparam int evt_width     = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       mode_rst   = 1'b0;
    localparam logic       irq_en_rst = 1'b0;
    localparam logic [7:0] byte_rst   = 8'h00;
    localparam logic [1:0] evt_rst    = 2'h0;

    // ------------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [1:0] htrans_seq    = 2'h3;

    typedef enum logic {edge_only, edge_and_level} detect_mode_e;

    // Latched address phase of a bus write
    typedef struct packed {
        logic       pending;
        logic [7:0] offset;
    } bus_wr_s;

endpackage

/* File: key_wake_irq_unit.sv */
`timescale 1ns/1ps

module key_wake_irq_unit #(
    parameter int PINS = 8
) (
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic            hready,
    input  wire logic [31:0]     hwdata,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    input  wire logic [PINS-1:0] key_pin,
    output logic      [PINS-1:0] pullup_en,
    output logic      [PINS-1:0] pulldown_en,
    output logic                 key_irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    key_wake_irq_pkg::detect_mode_e detect_mode_ff;
    key_wake_irq_pkg::bus_wr_s      wr_ff;
    logic                 key_irq_enable_ff;
    logic                 key_event_flag_ff;
    logic                 armed_ff;
    logic [PINS-1:0]      pin_detect_enable_ff;
    logic [PINS-1:0]      pin_polarity_select_ff;
    logic [PINS-1:0]      port_pull_enable_ff;
    logic [PINS-1:0]      sync1_ff;
    logic [PINS-1:0]      sync2_ff;
    logic [PINS-1:0]      prev_asserted_ff;
    logic [1:0]           evt_status_ff;
    logic [1:0]           evt_mask_ff;
    logic [31:0]          hrdata_ff;
    logic                 hreadyout_ff;
    logic                 key_irq_ff;
    logic                 hresp_ff;
    logic [PINS-1:0]      pullup_ff;
    logic [PINS-1:0]      pulldown_ff;

    logic [PINS-1:0]      asserted;
    logic [PINS-1:0]      edge_seen;
    logic                 any_asserted;
    logic                 valid_edge;
    logic                 level_set;
    logic                 flag_set;
    logic                 ack_write;
    logic                 flag_clear;
    logic                 addr_phase;
    logic                 wr_do;
    logic [31:0]          nxt_rdata;
    logic [1:0]           nxt_evt_status;
    logic                 ctrl_wr;
    logic                 enable_wr;
    logic                 polarity_wr;
    logic                 pull_wr;
    logic                 status_wr;
    logic                 mask_wr;
    logic                 flag_req;
    logic                 status_req;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Keys are asynchronous to core_clk; only sync2_ff is used downstream.
    // Two stages cost two clocks of latency but keep metastability out.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= key_pin;
            sync2_ff <= sync1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------------
    always_comb begin
        // Polarity one: high asserted; zero: low asserted
        asserted     = pin_detect_enable_ff &
                       ~(sync2_ff ^ pin_polarity_select_ff);
        // Previous sample deasserted and current asserted, per pin
        edge_seen    = asserted & ~prev_asserted_ff;
        any_asserted = |asserted;
        valid_edge   = armed_ff & (|edge_seen);
        level_set    = (detect_mode_ff == key_wake_irq_pkg::edge_and_level)
                       & any_asserted;
        flag_set     = valid_edge | level_set;
    end

    // Previous state is held for disabled pins as deasserted, so a pin
    // that is enabled while already asserted looks like a fresh edge.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_asserted_ff <= '0;
        end else begin
            prev_asserted_ff <= asserted;
        end
    end

    // Rearm only after every enabled input has gone back to deasserted;
    // reset clears it, but with no pin enabled yet it arms on the next clock.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            armed_ff <= 1'b0;
        end else if (valid_edge) begin
            armed_ff <= 1'b0;
        end else if (!any_asserted) begin
            armed_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Event flag
    // ------------------------------------------------------------------
    always_comb begin
        ack_write  = ctrl_wr && hwdata[key_wake_irq_pkg::ack_bit];
        // In level mode a still-asserted input also feeds flag_set,
        // which keeps the flag up across the acknowledge.
        flag_clear = ack_write &&
                     ((detect_mode_ff == key_wake_irq_pkg::edge_only) ||
                      !any_asserted);
    end

    // Set wins over clear so an event in the acknowledge cycle survives
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_event_flag_ff <= 1'b0;
        end else if (flag_set) begin
            key_event_flag_ff <= 1'b1;
        end else if (flag_clear) begin
            key_event_flag_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave, address phase capture
    // ------------------------------------------------------------------
    always_comb begin
        addr_phase = hsel && hready &&
                     (htrans == key_wake_irq_pkg::htrans_nonseq ||
                      htrans == key_wake_irq_pkg::htrans_seq);
        wr_do      = wr_ff.pending;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ff <= '0;
        end else begin
            wr_ff.pending <= addr_phase && hwrite;
            wr_ff.offset  <= haddr[7:0];
        end
    end

    // Write strobes, one per register, valid in the data phase; hsize is
    // not decoded since every register is one aligned word
    always_comb begin
        ctrl_wr     = wr_do && wr_ff.offset == key_wake_irq_pkg::key_ctrl_status_off;
        enable_wr   = wr_do && wr_ff.offset == key_wake_irq_pkg::pin_enable_off;
        polarity_wr = wr_do && wr_ff.offset == key_wake_irq_pkg::polarity_select_off;
        pull_wr     = wr_do && wr_ff.offset == key_wake_irq_pkg::port_pull_off;
        status_wr   = wr_do && wr_ff.offset == key_wake_irq_pkg::event_status_off;
        mask_wr     = wr_do && wr_ff.offset == key_wake_irq_pkg::event_mask_off;
    end

    // Never stalls, always OKAY
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
        end
    end

    // Registered so every bus output leaves a flop; errors are never sent
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = '0;
        unique case (haddr[7:0])
            key_wake_irq_pkg::key_ctrl_status_off: begin
                nxt_rdata[key_wake_irq_pkg::mode_bit]   = detect_mode_ff;
                nxt_rdata[key_wake_irq_pkg::irq_en_bit] = key_irq_enable_ff;
                nxt_rdata[key_wake_irq_pkg::flag_bit]   = key_event_flag_ff;
                // Acknowledge bit stays zero on reads
                nxt_rdata[key_wake_irq_pkg::ack_bit]    = 1'b0;
            end
            key_wake_irq_pkg::pin_enable_off:      nxt_rdata[PINS-1:0] = pin_detect_enable_ff;
            key_wake_irq_pkg::polarity_select_off: nxt_rdata[PINS-1:0] = pin_polarity_select_ff;
            key_wake_irq_pkg::port_pull_off:       nxt_rdata[PINS-1:0] = port_pull_enable_ff;
            key_wake_irq_pkg::event_status_off:    nxt_rdata[1:0]      = evt_status_ff;
            key_wake_irq_pkg::event_mask_off:      nxt_rdata[1:0]      = evt_mask_ff;
            default:                               nxt_rdata           = '0;
        endcase
    end

    // Read data is fetched in the address phase; a read issued in the
    // data phase of a write to the same word sees the old value.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hrdata_ff <= '0;
        end else if (addr_phase && !hwrite) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            detect_mode_ff    <= key_wake_irq_pkg::edge_only;
            key_irq_enable_ff <= key_wake_irq_pkg::irq_en_rst;
        end else if (ctrl_wr) begin
            detect_mode_ff    <= key_wake_irq_pkg::detect_mode_e'(
                                 hwdata[key_wake_irq_pkg::mode_bit]);
            key_irq_enable_ff <= hwdata[key_wake_irq_pkg::irq_en_bit];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_detect_enable_ff   <= key_wake_irq_pkg::byte_rst[PINS-1:0];
            pin_polarity_select_ff <= key_wake_irq_pkg::byte_rst[PINS-1:0];
            port_pull_enable_ff    <= key_wake_irq_pkg::byte_rst[PINS-1:0];
        end else if (wr_do) begin
            if (enable_wr) begin
                pin_detect_enable_ff <= hwdata[PINS-1:0];
            end
            if (polarity_wr) begin
                pin_polarity_select_ff <= hwdata[PINS-1:0];
            end
            if (pull_wr) begin
                port_pull_enable_ff <= hwdata[PINS-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pull resistor steering
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pullup_ff   <= '0;
            pulldown_ff <= '0;
        end else begin
            pullup_ff   <= port_pull_enable_ff & ~pin_polarity_select_ff;
            pulldown_ff <= port_pull_enable_ff & pin_polarity_select_ff;
        end
    end

    // ------------------------------------------------------------------
    // Event status and mask
    // ------------------------------------------------------------------
    always_comb begin
        nxt_evt_status = evt_status_ff;
        if (status_wr) begin
            nxt_evt_status = evt_status_ff & ~hwdata[1:0];
        end
        // Hardware set applied after the clear so it wins
        nxt_evt_status[key_wake_irq_pkg::evt_edge_bit] =
            nxt_evt_status[key_wake_irq_pkg::evt_edge_bit] | valid_edge;
        nxt_evt_status[key_wake_irq_pkg::evt_level_bit] =
            nxt_evt_status[key_wake_irq_pkg::evt_level_bit] | level_set;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            evt_status_ff <= key_wake_irq_pkg::evt_rst;
        end else begin
            evt_status_ff <= nxt_evt_status;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            evt_mask_ff <= key_wake_irq_pkg::evt_rst;
        end else if (mask_wr) begin
            evt_mask_ff <= hwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // Two sources share the one line: the key flag gated by its enable,
    // and any sticky status bit that the mask lets through
    always_comb begin
        flag_req   = key_event_flag_ff & key_irq_enable_ff;
        status_req = |(evt_status_ff & evt_mask_ff);
    end

    // Registered for a clean output; lags the flag by one clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_irq_ff <= 1'b0;
        end else begin
            key_irq_ff <= flag_req | status_req;
        end
    end

    assign hrdata      = hrdata_ff;
    assign hreadyout   = hreadyout_ff;
    assign hresp       = hresp_ff;
    assign pullup_en   = pullup_ff;
    assign pulldown_en = pulldown_ff;
    assign key_irq     = key_irq_ff;

endmodule

/* File: test_key_wake_irq_unit.sv */
`timescale 1ns/1ps

module test_key_wake_irq_unit;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  key_pin;
    logic [7:0]  pullup_en;
    logic [7:0]  pulldown_en;
    logic        key_irq;
    logic [7:0]  press    = 8'h0;
    logic [7:0]  act      = 8'h0;
    int          fails    = 0;
    int          compares = 0;

    always #2.5 core_clk = ~core_clk;

    key_wake_irq_unit #(.PINS(8)) key_wake_irq_unit_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .key_pin(key_pin), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
        .key_irq(key_irq));
    key_switch_model key_switch_model_i (.press(press), .act(act),
        .pullup_en(pullup_en), .pulldown_en(pulldown_en), .key_pin(key_pin));

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, off};
        hwrite <= wr;
        htrans <= key_wake_irq_pkg::htrans_nonseq;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] off, input logic [31:0] wd);
        logic [31:0] unused;
        bus(1'b1, off, wd, unused);
    endtask

    task automatic rd_check(input string what, input logic [7:0] off, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, off, 32'h0, v);
        check(what, v, exp);
    endtask

    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values;
        for (int a = 0; a <= 24; a += 4) rd_check("reset reg", a[7:0], 32'h0);
        check("irq at reset", {31'h0, key_irq}, 32'h0);
        $display("test reset_values done");
    endtask

    task automatic t_falling_edge;
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'hff);
        wr(8'h04, 32'h01);
        wr(8'h00, 32'h4);
        wr(8'h00, 32'h2);
        wr(8'h00, 32'h0a);
        rd_check("flag not writable", 8'h00, 32'h02);
        check("pullups", {24'h0, pullup_en}, 32'hff);
        check("pulldowns", {24'h0, pulldown_en}, 32'h0);
        @(posedge core_clk) press <= 8'h02;
        settle();
        rd_check("disabled pin", 8'h00, 32'h02);
        @(posedge core_clk) press <= 8'h01;
        settle();
        rd_check("falling flag", 8'h00, 32'h0a);
        check("irq on", {31'h0, key_irq}, 32'h1);
        wr(8'h00, 32'h6);
        rd_check("edge ack", 8'h00, 32'h02);
        wr(8'h04, 32'h03);
        @(posedge core_clk) press <= 8'h03;
        settle();
        rd_check("not rearmed", 8'h00, 32'h02);
        check("irq off", {31'h0, key_irq}, 32'h0);
        @(posedge core_clk) press <= 8'h00;
        settle();
        @(posedge core_clk) press <= 8'h02;
        settle();
        rd_check("rearmed", 8'h00, 32'h0a);
        @(posedge core_clk) press <= 8'h00;
        settle();
        wr(8'h00, 32'h6);
        $display("test falling_edge done");
    endtask

    task automatic t_rising_level;
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h01);
        wr(8'h0c, 32'h01);
        settle();
        check("pulldown sel", {24'h0, pulldown_en}, 32'h01);
        check("pullup off", {24'h0, pullup_en}, 32'h0);
        @(posedge core_clk) act <= 8'h01;
        settle();
        wr(8'h00, 32'h5);
        wr(8'h00, 32'h3);
        rd_check("no spurious", 8'h00, 32'h03);
        wr(8'h10, 32'h3);
        @(posedge core_clk) press <= 8'h01;
        settle();
        rd_check("rising flag", 8'h00, 32'h0b);
        rd_check("rising edge", 8'h10, 32'h3);
        wr(8'h00, 32'h7);
        rd_check("ack refused", 8'h00, 32'h0b);
        check("irq held", {31'h0, key_irq}, 32'h1);
        @(posedge core_clk) press <= 8'h00;
        settle();
        wr(8'h00, 32'h7);
        settle();
        rd_check("level ack", 8'h00, 32'h03);
        check("irq cleared", {31'h0, key_irq}, 32'h0);
        $display("test rising_level done");
    endtask

    task automatic t_status_irq;
        wr(8'h00, 32'h1);
        rd_check("status set", 8'h10, 32'h3);
        wr(8'h14, 32'h3);
        settle();
        check("masked irq on", {31'h0, key_irq}, 32'h1);
        wr(8'h14, 32'h0);
        settle();
        check("mask blocks", {31'h0, key_irq}, 32'h0);
        wr(8'h10, 32'h3);
        rd_check("status w1c", 8'h10, 32'h0);
        wr(8'h14, 32'h3);
        settle();
        check("cleared irq", {31'h0, key_irq}, 32'h0);
        $display("test status_irq done");
    endtask

    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_falling_edge();
        t_rising_level();
        t_status_irq();
        end_of_test();
    end
endmodule
